// ### core/bit_carry_and_branch_cond.sv
// Carry bit operations and branch/call sequencing behind an APB slave.
// Assumes operand fetch and address calculation happen outside; software
// loads the operand byte, flags and target, then writes the control word.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
module bit_carry_and_branch_cond
	import bit_carry_and_branch_cond_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB request
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	// APB answer
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Datapath view
	output logic             carry_flag,
	output logic [23:0]      program_counter,
	output logic             branch_taken
);

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic                         carry;
		logic                         zero;
		logic                         overflow;
		logic                         negative;
		logic [7:0]                   operand;
		logic [2:0]                   bitreg;
		logic [23:0]                  pc;
		logic [23:0]                  target;
		logic                         taken;
		logic                         err;
		logic [2:0]                   depth;
		logic [STACK_DEPTH-1:0][23:0] stack;
	} state_t;

	state_t      cur;
	state_t      next_cur;

	logic        access;
	logic        wr;
	logic        mapped;
	logic [7:0]  reg_addr;
	logic [3:0]  ctrl_op;
	logic [2:0]  ctrl_pos;
	logic        ctrl_from_reg;
	logic [3:0]  ctrl_cond;
	logic        inverted_op;
	logic [2:0]  bit_pos;
	logic        sel_bit;
	logic        cond_true;
	logic [23:0] seq_pc;
	logic [23:0] rel_pc;
	logic [31:0] rd_mux;

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	// Zero wait state slave
	assign access   = psel & penable;
	assign wr       = access & pwrite;
	assign reg_addr = paddr[7:0];
	assign pready   = 1'b1;

	// Known register window
	always_comb
	begin
		case (reg_addr)
			ADDR_CTRL, ADDR_FLAGS, ADDR_OPERAND, ADDR_BITREG,
			ADDR_PC, ADDR_TARGET, ADDR_STATUS, ADDR_RETTOP:
				mapped = (paddr[31:8] == 24'h000000);
			default:
				mapped = 1'b0;
		endcase
	end

	// Error answer for holes
	assign pslverr = access & ~mapped;

	////////////////////////////////////////////////////////////////////////
	// Control word fields

	assign ctrl_op       = pwdata[CTRL_OP_LSB +: 4];
	assign ctrl_pos      = pwdata[CTRL_POS_LSB +: 3];
	assign ctrl_from_reg = pwdata[CTRL_FROM_REG];
	assign ctrl_cond     = pwdata[CTRL_COND_LSB +: 4];

	// Inverted forms
	always_comb
	begin
		case (ctrl_op)
			OP_IOR, OP_IXOR, OP_ILD, OP_IST: inverted_op = 1'b1;
			default:                         inverted_op = 1'b0;
		endcase
	end

	// Bit number source
	assign bit_pos = (ctrl_from_reg & ~inverted_op) ? cur.bitreg
		: ctrl_pos;                                         // RULE_09
	assign sel_bit = cur.operand[bit_pos];

	// Sequential and relative addresses
	assign seq_pc = cur.pc + INSTR_LEN;
	assign rel_pc = seq_pc + cur.target;

	////////////////////////////////////////////////////////////////////////
	// Condition evaluation

	branch_cond_eval u_cond (
		.cond      (ctrl_cond),
		.carry     (cur.carry),
		.zero      (cur.zero),
		.overflow  (cur.overflow),
		.negative  (cur.negative),
		.cond_true (cond_true)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	// Register writes and operation execution
	always_comb
	begin
		next_cur = cur;
		if (wr && mapped)
		begin
			case (reg_addr)
				ADDR_FLAGS:
				begin
					if (pstrb[0])
					begin
						next_cur.carry    = pwdata[FLAG_C];
						next_cur.zero     = pwdata[FLAG_Z];
						next_cur.overflow = pwdata[FLAG_V];
						next_cur.negative = pwdata[FLAG_N];
					end
				end
				ADDR_OPERAND:
				begin
					if (pstrb[0])
						next_cur.operand = pwdata[7:0];
				end
				ADDR_BITREG:
				begin
					if (pstrb[0])
						next_cur.bitreg = pwdata[2:0];
				end
				ADDR_PC:
				begin
					if (pstrb[0])
						next_cur.pc[7:0] = pwdata[7:0];
					if (pstrb[1])
						next_cur.pc[15:8] = pwdata[15:8];
					if (pstrb[2])
						next_cur.pc[23:16] = pwdata[23:16];
				end
				ADDR_TARGET:
				begin
					if (pstrb[0])
						next_cur.target[7:0] = pwdata[7:0];
					if (pstrb[1])
						next_cur.target[15:8] = pwdata[15:8];
					if (pstrb[2])
						next_cur.target[23:16] = pwdata[23:16];
				end
				ADDR_STATUS:
				begin
					// Write one clears the error flag
					if (pstrb[0] && pwdata[STAT_ERR])
						next_cur.err = 1'b0;
				end
				ADDR_CTRL:
				begin
					if (pstrb[0])
					begin
						next_cur.taken = 1'b0;
						case (ctrl_op)
							OP_OR:
								next_cur.carry = cur.carry | sel_bit;    // RULE_01
							OP_IOR:
								next_cur.carry = cur.carry | ~sel_bit;   // RULE_02
							OP_XOR:
								next_cur.carry = cur.carry ^ sel_bit;    // RULE_03
							OP_IXOR:
								next_cur.carry = cur.carry ^ ~sel_bit;   // RULE_04
							OP_LD:
								next_cur.carry = sel_bit;                // RULE_05
							OP_ILD:
								next_cur.carry = ~sel_bit;               // RULE_06
							OP_ST:
								next_cur.operand[bit_pos] = cur.carry;   // RULE_07
							OP_IST:
								next_cur.operand[bit_pos] = ~cur.carry;  // RULE_08
							OP_BCC:
							begin
								// Taken goes relative, else falls through
								next_cur.taken = cond_true;              // RULE_10
								next_cur.pc    = cond_true ? rel_pc
									: seq_pc;                            // RULE_10
							end
							OP_JUMP:
							begin
								next_cur.taken = 1'b1;
								next_cur.pc    = cur.target;             // RULE_13
							end
							OP_CALL_REL, OP_CALL_ABS:
							begin
								if (cur.depth == 3'(STACK_DEPTH))
									next_cur.err = 1'b1;
								else
								begin
									// Save return, then go
									next_cur.stack[cur.depth[1:0]] = seq_pc; // RULE_13
									next_cur.depth = cur.depth + 3'h1;
									next_cur.taken = 1'b1;
									next_cur.pc    = (ctrl_op == OP_CALL_REL)
										? rel_pc : cur.target;           // RULE_13
								end
							end
							OP_RTS:
							begin
								if (cur.depth == 3'h0)
									next_cur.err = 1'b1;
								else
								begin
									// Restore saved return address
									next_cur.depth = cur.depth - 3'h1;
									next_cur.pc    =
										cur.stack[2'(cur.depth - 3'h1)]; // RULE_13
									next_cur.taken = 1'b1;
								end
							end
							default:
								next_cur.taken = 1'b0;
						endcase
					end
				end
				default:
					next_cur = cur;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur          <= '0;
			cur.pc       <= PC_RESET;
			cur.carry    <= FLAGS_RESET[FLAG_C];
			cur.zero     <= FLAGS_RESET[FLAG_Z];
			cur.overflow <= FLAGS_RESET[FLAG_V];
			cur.negative <= FLAGS_RESET[FLAG_N];
		end
		else
			cur <= next_cur;
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	// Read mux over stored state
	always_comb
	begin
		rd_mux = 32'h00000000;
		case (reg_addr)
			ADDR_FLAGS:
			begin
				rd_mux[FLAG_C] = cur.carry;
				rd_mux[FLAG_Z] = cur.zero;
				rd_mux[FLAG_V] = cur.overflow;
				rd_mux[FLAG_N] = cur.negative;
			end
			ADDR_OPERAND: rd_mux[7:0]  = cur.operand;
			ADDR_BITREG:  rd_mux[2:0]  = cur.bitreg;
			ADDR_PC:      rd_mux[23:0] = cur.pc;
			ADDR_TARGET:  rd_mux[23:0] = cur.target;
			ADDR_STATUS:
			begin
				rd_mux[STAT_TAKEN]        = cur.taken;
				rd_mux[STAT_DEPTH +: 3]   = cur.depth;
				rd_mux[STAT_ERR]          = cur.err;
			end
			ADDR_RETTOP:
			begin
				if (cur.depth != 3'h0)
					rd_mux[23:0] = cur.stack[2'(cur.depth - 3'h1)];
			end
			default:      rd_mux = 32'h00000000;
		endcase
	end

	// Data only during a mapped read access
	assign prdata = (access && !pwrite && mapped) ? rd_mux : 32'h00000000;

	// Datapath outputs straight from state
	assign carry_flag      = cur.carry;
	assign program_counter = cur.pc;
	assign branch_taken    = cur.taken;

endmodule // bit_carry_and_branch_cond

// ### core/bit_carry_and_branch_cond_pkg.sv
// Constants for the carry bit-operation and branch-condition unit.
// Assumes an APB slave with 32-bit data, one aligned word per register.
//
// Behaviour
// RULE_01 - Bit OR puts carry OR the selected operand bit into carry.
// RULE_02 - Inverted bit OR puts carry OR the inverse selected bit in carry.
// RULE_03 - Bit XOR puts carry XOR the selected operand bit into carry.
// RULE_04 - Inverted bit XOR puts carry XOR the inverse selected bit in carry.
// RULE_05 - Bit load copies the selected bit into carry, operand untouched.
// RULE_06 - Inverted bit load copies the inverse selected bit into carry.
// RULE_07 - Carry store writes carry into the selected operand bit.
// RULE_08 - Inverted carry store writes inverse carry into the selected bit.
// RULE_09 - Inverted variants take the bit number only from the immediate.
// RULE_10 - A branch jumps only when its condition holds; one is always true.
// RULE_11 - Unsigned tests use carry OR zero, and carry alone.
// RULE_12 - Zero, overflow, negative tests are direct; signed use N XOR V.
// RULE_13 - Jump, relative and absolute calls saving return, and return.
package bit_carry_and_branch_cond_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_FLAGS   = 8'h04;
	localparam logic [7:0] ADDR_OPERAND = 8'h08;
	localparam logic [7:0] ADDR_BITREG  = 8'h0c;
	localparam logic [7:0] ADDR_PC      = 8'h10;
	localparam logic [7:0] ADDR_TARGET  = 8'h14;
	localparam logic [7:0] ADDR_STATUS  = 8'h18;
	localparam logic [7:0] ADDR_RETTOP  = 8'h1c;

	// Control word fields
	localparam int CTRL_OP_LSB   = 0;
	localparam int CTRL_POS_LSB  = 4;
	localparam int CTRL_FROM_REG = 7;
	localparam int CTRL_COND_LSB = 8;

	// Flag word fields
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_V = 2;
	localparam int FLAG_N = 3;

	// Status word fields
	localparam int STAT_TAKEN   = 0;
	localparam int STAT_DEPTH   = 1;
	localparam int STAT_ERR     = 4;

	// Widths, sizes and reset values
	localparam int ADDR_W      = 24;
	localparam int STACK_DEPTH = 4;
	localparam logic [23:0] PC_RESET  = 24'h000000;
	localparam logic [23:0] INSTR_LEN = 24'h000002;
	localparam logic [3:0]  FLAGS_RESET = 4'h0;

	// Operation codes
	typedef enum logic [3:0] {
		OP_NONE     = 4'h0,
		OP_OR       = 4'h1,
		OP_IOR      = 4'h2,
		OP_XOR      = 4'h3,
		OP_IXOR     = 4'h4,
		OP_LD       = 4'h5,
		OP_ILD      = 4'h6,
		OP_ST       = 4'h7,
		OP_IST      = 4'h8,
		OP_BCC      = 4'h9,
		OP_JUMP     = 4'ha,
		OP_CALL_REL = 4'hb,
		OP_CALL_ABS = 4'hc,
		OP_RTS      = 4'hd
	} op_t;

	// Branch condition codes
	localparam logic [3:0] COND_ALWAYS = 4'h0;
	localparam logic [3:0] COND_NEVER  = 4'h1;
	localparam logic [3:0] COND_HI     = 4'h2;
	localparam logic [3:0] COND_LS     = 4'h3;
	localparam logic [3:0] COND_CC     = 4'h4;
	localparam logic [3:0] COND_CS     = 4'h5;
	localparam logic [3:0] COND_NE     = 4'h6;
	localparam logic [3:0] COND_EQ     = 4'h7;
	localparam logic [3:0] COND_VC     = 4'h8;
	localparam logic [3:0] COND_VS     = 4'h9;
	localparam logic [3:0] COND_PL     = 4'ha;
	localparam logic [3:0] COND_MI     = 4'hb;
	localparam logic [3:0] COND_GE     = 4'hc;
	localparam logic [3:0] COND_LT     = 4'hd;
	localparam logic [3:0] COND_GT     = 4'he;
	localparam logic [3:0] COND_LE     = 4'hf;

endpackage

// ### core/branch_cond_eval.sv
// Branch condition evaluator, purely combinational.
// Assumes flags are stable registered values from the caller.
`timescale 1ns/1ps
module branch_cond_eval
	import bit_carry_and_branch_cond_pkg::*;
(
	// Condition select
	input  wire logic [3:0] cond,
	// Flags
	input  wire logic       carry,
	input  wire logic       zero,
	input  wire logic       overflow,
	input  wire logic       negative,
	// Result
	output logic            cond_true
);

	logic lo_same;
	logic sign_lt;
	logic sign_le;

	// Shared compare terms
	assign lo_same = carry | zero;             // RULE_11
	assign sign_lt = negative ^ overflow;      // RULE_12
	assign sign_le = zero | sign_lt;           // RULE_12

	// Condition table
	always_comb
	begin
		case (cond)
			COND_ALWAYS: cond_true = 1'b1;       // RULE_10
			COND_NEVER:  cond_true = 1'b0;       // RULE_10
			COND_HI:     cond_true = ~lo_same;   // RULE_11
			COND_LS:     cond_true = lo_same;    // RULE_11
			COND_CC:     cond_true = ~carry;     // RULE_11
			COND_CS:     cond_true = carry;      // RULE_11
			COND_NE:     cond_true = ~zero;      // RULE_12
			COND_EQ:     cond_true = zero;       // RULE_12
			COND_VC:     cond_true = ~overflow;  // RULE_12
			COND_VS:     cond_true = overflow;   // RULE_12
			COND_PL:     cond_true = ~negative;  // RULE_12
			COND_MI:     cond_true = negative;   // RULE_12
			COND_GE:     cond_true = ~sign_lt;   // RULE_12
			COND_LT:     cond_true = sign_lt;    // RULE_12
			COND_GT:     cond_true = ~sign_le;   // RULE_12
			COND_LE:     cond_true = sign_le;    // RULE_12
			default:     cond_true = 1'b0;
		endcase
	end

endmodule // branch_cond_eval

// ### dv/bit_carry_and_branch_cond_chk.sv
// Checker for the carry bit-op and branch unit, APB side and datapath view.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module bit_carry_and_branch_cond_chk
	import bit_carry_and_branch_cond_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB request and answer
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Datapath view
	input wire logic        carry_flag,
	input wire logic [23:0] program_counter,
	input wire logic        branch_taken
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	// Access decode and control-word fields
	wire       acc = psel && penable;
	wire       mapped = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0);
	wire       ctl = acc && pwrite && (paddr == 32'h0) && pstrb[0];
	wire [3:0] op = pwdata[3:0];
	wire [3:0] cnd = pwdata[11:8];
	////////////////////////////////////////////////////////////////////////
	property p_ready; pready == 1'b1; endproperty
	a_ready: assert property (p_ready) else $error("pready low");
	property p_err; acc |-> pslverr == !mapped; endproperty
	a_err: assert property (p_err) else $error("pslverr wrong");
	property p_idle; !acc |-> prdata == 32'h0 && !pslverr; endproperty
	a_idle: assert property (p_idle) else $error("idle answer not quiet");
	property p_carry_cause;
		!$stable(carry_flag) |-> $past(acc) && $past(pwrite);
	endproperty
	a_carry_cause: assert property (p_carry_cause)
		else $error("carry changed without a write");
	property p_pc_cause;
		!$stable(program_counter) |-> $past(acc) && $past(pwrite);
	endproperty
	a_pc_cause: assert property (p_pc_cause)
		else $error("pc changed without a write");
	property p_always;
		ctl && op == OP_BCC && cnd == COND_ALWAYS |=> branch_taken;
	endproperty
	a_always: assert property (p_always)
		else $error("always-true branch not taken");
	property p_never;
		ctl && op == OP_BCC && cnd == COND_NEVER |=> !branch_taken
			&& program_counter == $past(program_counter) + 24'h2;
	endproperty
	a_never: assert property (p_never)
		else $error("never-true branch misbehaved");
	property p_bitop;
		ctl && op inside {[OP_OR:OP_IST]} |=>
			$stable(program_counter) && !branch_taken;
	endproperty
	a_bitop: assert property (p_bitop)
		else $error("bit op moved pc or left taken");
	property p_store;
		ctl && (op == OP_ST || op == OP_IST) |=> $stable(carry_flag);
	endproperty
	a_store: assert property (p_store)
		else $error("store changed carry");
	property p_branch_c; ctl && op == OP_BCC |=> $stable(carry_flag);
	endproperty
	a_branch_c: assert property (p_branch_c)
		else $error("branch changed carry");
	// Main scenarios reached
	c_branch: cover property (ctl && op == OP_BCC);
	c_istore: cover property (ctl && op == OP_IST);
	c_unmapped: cover property (acc && pslverr);
endmodule // bit_carry_and_branch_cond_chk

bind bit_carry_and_branch_cond bit_carry_and_branch_cond_chk chk_u (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .pready, .pslverr, .carry_flag, .program_counter,
	.branch_taken);

// ### dv/bit_carry_and_branch_cond_tb.sv
// Self-checking bench for the carry bit-op and branch unit over APB.
// Assumes zero-wait APB slave and the register map of the package.
`timescale 1ns/1ps
module bit_carry_and_branch_cond_tb;
	import bit_carry_and_branch_cond_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        carry_flag;
	logic [23:0] program_counter;
	logic        branch_taken;
	logic [31:0] r;
	logic        e_last;
	logic [3:0]  o;
	logic [3:0]  f;
	logic [7:0]  opnd;
	logic [2:0]  p;
	logic [8:0]  ex;
	logic        t;
	logic        fr;
	logic        u;
	logic        s;
	int          mismatches;
	int          tests_run;
	bit_carry_and_branch_cond dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .carry_flag(carry_flag),
		.program_counter(program_counter), .branch_taken(branch_taken));
	////////////////////////////////////////////////////////////////////////
	// Verdict and run end
	task results;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Compare one value
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e_last = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(r, exp);
	endtask
	// Expected carry and operand after a bit op
	function automatic logic [8:0] bitop(input logic [3:0] k,
		input logic c, input logic [7:0] v, input logic [2:0] q);
		logic       b;
		logic       nc;
		logic [7:0] nv;
		b = v[q];
		nc = c;
		nv = v;
		case (k)
			OP_OR: nc = c | b;
			OP_IOR: nc = c | ~b;
			OP_XOR: nc = c ^ b;
			OP_IXOR: nc = c ^ ~b;
			OP_LD: nc = b;
			OP_ILD: nc = ~b;
			OP_ST: nv[q] = c;
			default: nv[q] = ~c;
		endcase
		return {nc, nv};
	endfunction
	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial
	begin
		#500000;
		mismatches++;
		$display("mismatch at %0t: watchdog", $time);
		results();
	end
	// Main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hf;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_FLAGS, 32'h0);
		rd(ADDR_PC, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_RETTOP, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, e_last}, 32'h1);
		chk(r, 32'h0);
		$display("test reset and unmapped done");
		// Every bit op, carry, bit value and bit-number source
		wr(ADDR_BITREG, 32'h2);
		for (int i = 0; i < 64; i++)
		begin
			o = 4'(i / 8 + 1);
			fr = i[2];
			opnd = i[1] ? 8'h20 : 8'h04;
			u = (o == OP_OR || o == OP_XOR || o == OP_LD || o == OP_ST);
			p = (fr && u) ? 3'd2 : 3'd5;
			ex = bitop(o, i[0], opnd, p);
			wr(ADDR_FLAGS, {31'h0, i[0]});
			wr(ADDR_OPERAND, {24'h0, opnd});
			wr(ADDR_CTRL, {24'h0, fr, 3'd5, o});
			rd(ADDR_FLAGS, {31'h0, ex[8]});
			chk({31'h0, carry_flag}, {31'h0, ex[8]});
			rd(ADDR_OPERAND, {24'h0, ex[7:0]});
		end
		$display("test bit ops done");
		// Every condition against every flag pattern
		wr(ADDR_TARGET, 32'h20);
		for (int i = 0; i < 256; i++)
		begin
			f = i[3:0];
			u = f[FLAG_C] | f[FLAG_Z];
			s = f[FLAG_N] ^ f[FLAG_V];
			case (i[7:4])
				COND_ALWAYS: t = 1'b1;
				COND_NEVER: t = 1'b0;
				COND_HI: t = !u;
				COND_LS: t = u;
				COND_CC: t = !f[FLAG_C];
				COND_CS: t = f[FLAG_C];
				COND_NE: t = !f[FLAG_Z];
				COND_EQ: t = f[FLAG_Z];
				COND_VC: t = !f[FLAG_V];
				COND_VS: t = f[FLAG_V];
				COND_PL: t = !f[FLAG_N];
				COND_MI: t = f[FLAG_N];
				COND_GE: t = !s;
				COND_LT: t = s;
				COND_GT: t = !(f[FLAG_Z] | s);
				default: t = f[FLAG_Z] | s;
			endcase
			wr(ADDR_FLAGS, {28'h0, f});
			wr(ADDR_PC, 32'h100);
			wr(ADDR_CTRL, {20'h0, 4'(i[7:4]), 4'h0, OP_BCC});
			rd(ADDR_PC, t ? 32'h122 : 32'h102);
			rd(ADDR_STATUS, {31'h0, t});
			chk({31'h0, branch_taken}, {31'h0, t});
			chk({8'h0, program_counter}, t ? 32'h122 : 32'h102);
		end
		$display("test conditions done");
		// Jump, calls, returns and a pop from the empty stack
		wr(ADDR_PC, 32'h40);
		wr(ADDR_TARGET, 32'h1000);
		wr(ADDR_CTRL, 32'h0000000a);
		rd(ADDR_PC, 32'h1000);
		wr(ADDR_TARGET, 32'h10);
		wr(ADDR_CTRL, 32'h0000000b);
		rd(ADDR_PC, 32'h1012);
		rd(ADDR_RETTOP, 32'h1002);
		wr(ADDR_TARGET, 32'h300);
		wr(ADDR_CTRL, 32'h0000000c);
		rd(ADDR_PC, 32'h300);
		rd(ADDR_RETTOP, 32'h1014);
		wr(ADDR_CTRL, {28'h0, OP_RTS});
		rd(ADDR_PC, 32'h1014);
		wr(ADDR_CTRL, {28'h0, OP_RTS});
		rd(ADDR_PC, 32'h1002);
		rd(ADDR_RETTOP, 32'h0);
		wr(ADDR_CTRL, {28'h0, OP_RTS});
		rd(ADDR_PC, 32'h1002);
		rd(ADDR_STATUS, 32'h10);
		wr(ADDR_STATUS, 32'h10);
		rd(ADDR_STATUS, 32'h0);
		$display("test jumps and calls done");
		// Stack overflow, idle op, byte lanes and unmapped write
		wr(ADDR_TARGET, 32'h100);
		repeat (4) wr(ADDR_CTRL, {28'h0, OP_CALL_ABS});
		rd(ADDR_STATUS, 32'h9);
		wr(ADDR_CTRL, {28'h0, OP_CALL_ABS});
		rd(ADDR_STATUS, 32'h18);
		chk({8'h0, program_counter}, 32'h100);
		chk({31'h0, branch_taken}, 32'h0);
		rd(ADDR_RETTOP, 32'h102);
		repeat (4) wr(ADDR_CTRL, {28'h0, OP_RTS});
		rd(ADDR_PC, 32'h1004);
		wr(ADDR_STATUS, 32'h10);
		rd(ADDR_STATUS, 32'h1);
		wr(ADDR_CTRL, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		pstrb <= 4'h1;
		wr(ADDR_PC, 32'h00abcdef);
		pstrb <= 4'hf;
		rd(ADDR_PC, 32'h10ef);
		apb(1'b1, 8'h20, 32'hff);
		chk({31'h0, e_last}, 32'h1);
		rd(ADDR_PC, 32'h10ef);
		$display("test stack and lanes done");
		results();
	end
endmodule // bit_carry_and_branch_cond_tb
